// *** hdl/line_bank_pkg.sv ***
// constants, field layout and shared decoding for the per-channel event status bank
package line_bank_pkg;

    localparam int          CHANNELS        = 8;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          CNT_W           = 16;
    localparam int          CHAN_LSB        = 5;
    localparam int          CHAN_W          = ADDR_W - CHAN_LSB;
    localparam int          OFF_W           = CHAN_LSB;
    localparam int          MATCH_W         = 2;

    localparam logic [ADDR_W-1:0] CHANNEL_STRIDE = 8'h20;
    localparam logic [OFF_W-1:0]  OFF_FLAGS_FIRST  = 5'h16;
    localparam logic [OFF_W-1:0]  OFF_FLAGS_SECOND = 5'h17;
    localparam logic [OFF_W-1:0]  OFF_COUNT_LOW    = 5'h18;
    localparam logic [OFF_W-1:0]  OFF_COUNT_HIGH   = 5'h19;
    localparam logic [OFF_W-1:0]  OFF_TERM         = 5'h1A;

    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] TERM_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] TERM_WMASK  = 8'h3F;
    localparam logic [DATA_W-1:0] READ_IDLE   = 8'h00;
    localparam logic [CNT_W-1:0]  COUNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0]  COUNT_ONE   = 16'h0001;
    localparam logic [CNT_W-1:0]  COUNT_MAX   = 16'hFFFF;

    // termination field layout and internal impedance codes
    localparam int          TX_TERM_LO  = 3;
    localparam int          TX_EXT_BIT  = 5;
    localparam int          RX_TERM_LO  = 0;
    localparam int          RX_EXT_BIT  = 2;
    localparam logic [1:0]  MATCH_75    = 2'h0;
    localparam logic [1:0]  MATCH_120   = 2'h1;
    localparam logic [1:0]  MATCH_100   = 2'h2;
    localparam logic [1:0]  MATCH_110   = 2'h3;

    // flag positions, first register
    localparam int          B1_EQ       = 7;
    localparam int          B1_LB_ACT   = 6;
    localparam int          B1_LB_DEACT = 5;
    localparam int          B1_PAT_SYNC = 4;
    localparam int          B1_TX_CLK   = 3;
    localparam int          B1_DRV_FAIL = 2;
    localparam int          B1_ALARM    = 1;
    localparam int          B1_SIG_LOSS = 0;
    // flag positions, second register
    localparam int          B2_WAVE_OV  = 7;
    localparam int          B2_JA_OV    = 6;
    localparam int          B2_JA_UD    = 5;
    localparam int          B2_PAT_ERR  = 4;
    localparam int          B2_EXZ      = 3;
    localparam int          B2_CV       = 2;
    localparam int          B2_TIMER    = 1;
    localparam int          B2_CNT_OV   = 0;

    // mask high blocks an event; edge select high means any change, low means rise only
    function automatic logic [DATA_W-1:0] event_hits(input logic [DATA_W-1:0] cur,
                                                     input logic [DATA_W-1:0] prev,
                                                     input logic [DATA_W-1:0] mask,
                                                     input logic [DATA_W-1:0] any_change);
        event_hits = ~mask & ((cur ^ prev) & (any_change | cur));
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input int unsigned       chan,
                                     input logic [OFF_W-1:0]  off);
        reg_hit = (addr[ADDR_W-1:CHAN_LSB] == CHAN_W'(chan)) && (addr[OFF_W-1:0] == off);
    endfunction

endpackage

// *** hdl/chan_event_bank.sv ***
// one channel: sticky event flags, error counter and termination select
`timescale 1ns/1ps
`default_nettype none

module chan_event_bank (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic [line_bank_pkg::DATA_W-1:0] status_first,
    input  wire logic [line_bank_pkg::DATA_W-1:1] status_second,
    input  wire logic [line_bank_pkg::DATA_W-1:0] mask_first,
    input  wire logic [line_bank_pkg::DATA_W-1:0] edge_first,
    input  wire logic [line_bank_pkg::DATA_W-1:0] mask_second,
    input  wire logic [line_bank_pkg::DATA_W-1:0] edge_second,
    input  wire logic                          count_tick,
    input  wire logic                          read_first,
    input  wire logic                          read_second,
    input  wire logic                          write_term,
    input  wire logic [line_bank_pkg::DATA_W-1:0] write_data,
    output logic      [line_bank_pkg::DATA_W-1:0] flags_first,
    output logic      [line_bank_pkg::DATA_W-1:0] flags_second,
    output logic      [line_bank_pkg::CNT_W-1:0]  count,
    output logic      [line_bank_pkg::DATA_W-1:0] term
);
    import line_bank_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] prev_first;
        logic [DATA_W-1:0] prev_second;
        logic [DATA_W-1:0] flags_first;
        logic [DATA_W-1:0] flags_second;
        logic [CNT_W-1:0]  count;
        logic [DATA_W-1:0] term;
    } chan_state_t;

    chan_state_t       st_r;
    chan_state_t       st_nxt;
    logic              error_counter_overflow_event;
    logic [DATA_W-1:0] cur_second;
    logic [DATA_W-1:0] hits_first;
    logic [DATA_W-1:0] hits_second;

    always_comb begin
        st_nxt = st_r;
        error_counter_overflow_event = count_tick && (st_r.count == COUNT_MAX);
        cur_second  = {status_second, error_counter_overflow_event};
        hits_first  = event_hits(status_first, st_r.prev_first, mask_first, edge_first);
        hits_second = event_hits(cur_second, st_r.prev_second, mask_second, edge_second);
        st_nxt.prev_first  = status_first;
        st_nxt.prev_second = cur_second;
        // a new event in the read cycle survives the clear
        st_nxt.flags_first  = (read_first ? FLAGS_RESET : st_r.flags_first) | hits_first;
        st_nxt.flags_second = (read_second ? FLAGS_RESET : st_r.flags_second) | hits_second;
        if (count_tick) begin
            st_nxt.count = st_r.count + COUNT_ONE;
        end
        if (write_term) begin
            st_nxt.term = write_data & TERM_WMASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{prev_first: FLAGS_RESET, prev_second: FLAGS_RESET,
                      flags_first: FLAGS_RESET, flags_second: FLAGS_RESET,
                      count: COUNT_RESET, term: TERM_RESET};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flags_first  = st_r.flags_first;
    assign flags_second = st_r.flags_second;
    assign count        = st_r.count;
    assign term         = st_r.term;

    a_first_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
        read_first |=> st_r.flags_first == $past(hits_first))
        else $error("first flags not cleared by read");

    a_second_read_clear: assert property (@(posedge clock) disable iff (!rst_n)
        read_second |=> st_r.flags_second == $past(hits_second))
        else $error("second flags not cleared by read");

    a_flags_stay_set: assert property (@(posedge clock) disable iff (!rst_n)
        !read_first |=> (st_r.flags_first & $past(st_r.flags_first)) == $past(st_r.flags_first))
        else $error("first flag dropped without read");

    a_rise_only_mode: assert property (@(posedge clock) disable iff (!rst_n)
        (!read_first && edge_first == FLAGS_RESET && st_r.flags_first == FLAGS_RESET
         && (status_first & ~st_r.prev_first) == FLAGS_RESET)
        |=> st_r.flags_first == FLAGS_RESET)
        else $error("flag set without rising edge");

    a_overflow_wraps_flags: assert property (@(posedge clock) disable iff (!rst_n)
        (count_tick && st_r.count == COUNT_MAX && !mask_second[B2_CNT_OV])
        |=> st_r.count == COUNT_RESET && st_r.flags_second[B2_CNT_OV])
        else $error("counter overflow not flagged");

endmodule // chan_event_bank

`default_nettype wire

// *** hdl/line_channel_event_status_bank.sv ***
// eight-channel interrupt status, error counter and termination register bank
//
// Function
// - reading the first flag register clears all its flags.
// - eight channel copies, 0x20 apart, first flag register of channel zero at 0x16.
// - first register bit 7 flags equalizer out of range.
// - first register bit 6 loopback activate code, bit 5 deactivate code.
// - first register bit 4 flags pattern synchronisation change.
// - first register bit 3 flags loss of channel transmit clock.
// - first register bits 2,1,0 flag driver failure, alarm indication, signal loss.
// - reading second flag register clears its flags and withdraws their interrupt; the interrupt stays up while any first-register flag is set.
// - second register bit 7 flags waveform amplitude overflow.
// - second register bit 6 jitter buffer overflow, bit 5 underflow.
// - second register bits 4,3,2: pattern bit error, excess zeros, code violation.
// - second register bit 1 one-second timer, bit 0 error counter overflow.
// - low counter byte read-only at 0x18, resets to zero.
// - high counter byte read-only at 0x19, resets to zero.
// - transmit termination bits 5..3: 75, 120, 100, 110 ohm; resets 000.
// - transmit code with top bit set selects external resistors, E1 only.
// - receive termination bits 2..0 same codes; top bit selects external resistors.
// - unmasked event flags on rise, or on any change in any-change mode.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module line_channel_event_status_bank (
    input  wire logic                                       clock,
    input  wire logic                                       rstn,
    input  wire logic [line_bank_pkg::ADDR_W-1:0]           address,
    input  wire logic [line_bank_pkg::DATA_W-1:0]           write_data,
    input  wire logic                                       write_strobe,
    input  wire logic                                       read_strobe,
    output logic      [line_bank_pkg::DATA_W-1:0]           read_data,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         equalizer_range_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         inband_loop_activate_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         inband_loop_deactivate_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         pattern_sync_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         tx_clock_missing_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         driver_failure_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         alarm_indication_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         signal_loss_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         waveform_amplitude_overflow_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         jitter_buffer_overflow_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         jitter_buffer_underflow_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         pattern_bit_error_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         excess_zeros_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         code_violation_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         one_second_timer_event,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         error_count_tick,
    input  wire logic [line_bank_pkg::CHANNELS-1:0]         e1_mode,
    input  wire logic [line_bank_pkg::CHANNELS*8-1:0]       first_event_mask,
    input  wire logic [line_bank_pkg::CHANNELS*8-1:0]       first_edge_select,
    input  wire logic [line_bank_pkg::CHANNELS*8-1:0]       second_event_mask,
    input  wire logic [line_bank_pkg::CHANNELS*8-1:0]       second_edge_select,
    output logic      [line_bank_pkg::CHANNELS-1:0]         interrupt_request,
    output logic      [line_bank_pkg::CHANNELS*2-1:0]       tx_internal_match,
    output logic      [line_bank_pkg::CHANNELS-1:0]         tx_external_match,
    output logic      [line_bank_pkg::CHANNELS*2-1:0]       rx_internal_match,
    output logic      [line_bank_pkg::CHANNELS-1:0]         rx_external_match
);
    import line_bank_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]           read_data;
        logic [CHANNELS-1:0]         irq;
        logic [CHANNELS*MATCH_W-1:0] tx_int;
        logic [CHANNELS-1:0]         tx_ext;
        logic [CHANNELS*MATCH_W-1:0] rx_int;
        logic [CHANNELS-1:0]         rx_ext;
    } top_state_t;

    top_state_t          st_r;
    top_state_t          st_nxt;
    logic [1:0]          rst_sync_r;
    logic                rst_n;

    logic [DATA_W-1:0]   flags_first  [CHANNELS];
    logic [DATA_W-1:0]   flags_second [CHANNELS];
    logic [CNT_W-1:0]    count        [CHANNELS];
    logic [DATA_W-1:0]   term         [CHANNELS];
    logic [CHANNELS-1:0] read_first;
    logic [CHANNELS-1:0] read_second;
    logic [CHANNELS-1:0] write_term;

    // reset is released through two flops so every flop reset by rst_n leaves reset on the same edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            logic [DATA_W-1:0] status_first;
            logic [DATA_W-1:1] status_second;

            always_comb begin
                status_first[B1_EQ]       = equalizer_range_event[c];
                status_first[B1_LB_ACT]   = inband_loop_activate_event[c];
                status_first[B1_LB_DEACT] = inband_loop_deactivate_event[c];
                status_first[B1_PAT_SYNC] = pattern_sync_event[c];
                status_first[B1_TX_CLK]   = tx_clock_missing_event[c];
                status_first[B1_DRV_FAIL] = driver_failure_event[c];
                status_first[B1_ALARM]    = alarm_indication_event[c];
                status_first[B1_SIG_LOSS] = signal_loss_event[c];
                status_second[B2_WAVE_OV] = waveform_amplitude_overflow_event[c];
                status_second[B2_JA_OV]   = jitter_buffer_overflow_event[c];
                status_second[B2_JA_UD]   = jitter_buffer_underflow_event[c];
                status_second[B2_PAT_ERR] = pattern_bit_error_event[c];
                status_second[B2_EXZ]     = excess_zeros_event[c];
                status_second[B2_CV]      = code_violation_event[c];
                status_second[B2_TIMER]   = one_second_timer_event[c];
            end

            // each channel decodes its own copy of the group
            assign read_first[c]  = read_strobe && reg_hit(address, c, OFF_FLAGS_FIRST);
            assign read_second[c] = read_strobe && reg_hit(address, c, OFF_FLAGS_SECOND);
            assign write_term[c]  = write_strobe && reg_hit(address, c, OFF_TERM);

            chan_event_bank u_bank (
                .clock         (clock),
                .rst_n         (rst_n),
                .status_first  (status_first),
                .status_second (status_second),
                .mask_first    (first_event_mask[c*DATA_W +: DATA_W]),
                .edge_first    (first_edge_select[c*DATA_W +: DATA_W]),
                .mask_second   (second_event_mask[c*DATA_W +: DATA_W]),
                .edge_second   (second_edge_select[c*DATA_W +: DATA_W]),
                .count_tick    (error_count_tick[c]),
                .read_first    (read_first[c]),
                .read_second   (read_second[c]),
                .write_term    (write_term[c]),
                .write_data    (write_data),
                .flags_first   (flags_first[c]),
                .flags_second  (flags_second[c]),
                .count         (count[c]),
                .term          (term[c])
            );

            a_first_read_data: assert property (@(posedge clock) disable iff (!rst_n)
                read_first[c] |=> read_data == $past(flags_first[c]))
                else $error("first flag register read wrong");

            a_second_read_data: assert property (@(posedge clock) disable iff (!rst_n)
                read_second[c] |=> read_data == $past(flags_second[c]))
                else $error("second flag register read wrong");

            a_count_low_read: assert property (@(posedge clock) disable iff (!rst_n)
                (read_strobe && reg_hit(address, c, OFF_COUNT_LOW))
                |=> read_data == $past(count[c][DATA_W-1:0]))
                else $error("low counter byte read wrong");

            a_count_high_read: assert property (@(posedge clock) disable iff (!rst_n)
                (read_strobe && reg_hit(address, c, OFF_COUNT_HIGH))
                |=> read_data == $past(count[c][CNT_W-1:DATA_W]))
                else $error("high counter byte read wrong");

            a_term_write_read: assert property (@(posedge clock) disable iff (!rst_n)
                write_term[c] ##1 (read_strobe && reg_hit(address, c, OFF_TERM))
                |=> read_data == ($past(write_data, 2) & TERM_WMASK))
                else $error("termination register did not hold write");

            a_tx_external_e1: assert property (@(posedge clock) disable iff (!rst_n)
                !e1_mode[c] |=> !tx_external_match[c])
                else $error("external transmit match outside E1");

            a_rx_external_sel: assert property (@(posedge clock) disable iff (!rst_n)
                term[c][RX_EXT_BIT] |=> rx_external_match[c]
                    && rx_internal_match[c*MATCH_W +: MATCH_W] == $past(term[c][RX_TERM_LO +: MATCH_W]))
                else $error("receive termination not applied");

            a_irq_withdrawn: assert property (@(posedge clock) disable iff (!rst_n)
                (read_second[c] && flags_first[c] == FLAGS_RESET) ##1
                (flags_first[c] == FLAGS_RESET && flags_second[c] == FLAGS_RESET)
                |=> !interrupt_request[c])
                else $error("interrupt request not withdrawn");
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        // read data stand for one cycle only, zero otherwise and for unmapped offsets
        st_nxt.read_data = READ_IDLE;
        if (read_strobe) begin
            case (address[OFF_W-1:0])
                OFF_FLAGS_FIRST: begin
                    st_nxt.read_data = flags_first[address[ADDR_W-1:CHAN_LSB]];
                end
                OFF_FLAGS_SECOND: begin
                    st_nxt.read_data = flags_second[address[ADDR_W-1:CHAN_LSB]];
                end
                OFF_COUNT_LOW: begin
                    st_nxt.read_data = count[address[ADDR_W-1:CHAN_LSB]][DATA_W-1:0];
                end
                // no snapshot: a count step between the two byte reads tears the value
                OFF_COUNT_HIGH: begin
                    st_nxt.read_data = count[address[ADDR_W-1:CHAN_LSB]][CNT_W-1:DATA_W];
                end
                OFF_TERM: begin
                    st_nxt.read_data = term[address[ADDR_W-1:CHAN_LSB]];
                end
                default: begin
                    st_nxt.read_data = READ_IDLE;
                end
            endcase
        end
        for (int i = 0; i < CHANNELS; i++) begin
            st_nxt.irq[i] = |(flags_first[i] | flags_second[i]);
            st_nxt.tx_int[i*MATCH_W +: MATCH_W] = term[i][TX_TERM_LO +: MATCH_W];
            // T1 and J1 never switch to external transmit resistors
            st_nxt.tx_ext[i] = term[i][TX_EXT_BIT] && e1_mode[i];
            st_nxt.rx_int[i*MATCH_W +: MATCH_W] = term[i][RX_TERM_LO +: MATCH_W];
            st_nxt.rx_ext[i] = term[i][RX_EXT_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{read_data: READ_IDLE, irq: '0, tx_int: '0, tx_ext: '0,
                      rx_int: '0, rx_ext: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign read_data         = st_r.read_data;
    assign interrupt_request = st_r.irq;
    assign tx_internal_match = st_r.tx_int;
    assign tx_external_match = st_r.tx_ext;
    assign rx_internal_match = st_r.rx_int;
    assign rx_external_match = st_r.rx_ext;

    a_unmapped_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (read_strobe && (address[OFF_W-1:0] < OFF_FLAGS_FIRST || address[OFF_W-1:0] > OFF_TERM))
        |=> read_data == READ_IDLE)
        else $error("unmapped read not zero");

    a_idle_read_zero: assert property (@(posedge clock) disable iff (!rst_n)
        !read_strobe |=> read_data == READ_IDLE)
        else $error("read data outside read cycle");

endmodule // line_channel_event_status_bank

`default_nettype wire

// *** tb/host.sv ***
// host bus master model for the register port
`timescale 1ns/1ps
`default_nettype none
module host (
    input  wire logic       clock,
    output logic [7:0]      address,
    output logic [7:0]      write_data,
    output logic            write_strobe,
    output logic            read_strobe
);
    logic [7:0] exp_q [$];
    logic       pend_r = 1'b0;
    initial {address, write_data, write_strobe, read_strobe} = 18'h00000;
    always @(posedge clock) pend_r <= read_strobe;
    // strobes stay up for back to back cycles; idle drops them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {address, write_data, write_strobe, read_strobe} <= {a, d, 2'h2};
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        {address, write_strobe, read_strobe} <= {a, 2'h1};
        exp_q.push_back(e);
        @(posedge clock);
    endtask
    task automatic idle();
        {write_strobe, read_strobe} <= 2'h0;
    endtask
endmodule // host
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the event status bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock = 1'b0, rstn = 1'b0, write_strobe, read_strobe;
    logic [7:0]  address, write_data, read_data, irq, tx_ext, rx_ext;
    logic [7:0]  e1_mode = 8'h00, tick = 8'h00;
    logic [7:0]  ev1 [8] = '{default: 8'h00}, ev2 [8] = '{default: 8'h00};
    logic [15:0] tx_int, rx_int;
    int          err_count = 0, total_checks = 0;
    logic [63:0] msk1 = '0, sel1 = '0, msk2 = '0, sel2 = '0;
    int unsigned ch, n, d, b, k;
    initial forever #25 clock = ~clock;
    host host_inst (.clock(clock), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe));
    line_channel_event_status_bank line_channel_event_status_bank_inst (
        .clock(clock), .rstn(rstn), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .equalizer_range_event(ev1[7]), .inband_loop_activate_event(ev1[6]),
        .inband_loop_deactivate_event(ev1[5]), .pattern_sync_event(ev1[4]),
        .tx_clock_missing_event(ev1[3]), .driver_failure_event(ev1[2]),
        .alarm_indication_event(ev1[1]), .signal_loss_event(ev1[0]),
        .waveform_amplitude_overflow_event(ev2[7]), .jitter_buffer_overflow_event(ev2[6]),
        .jitter_buffer_underflow_event(ev2[5]), .pattern_bit_error_event(ev2[4]),
        .excess_zeros_event(ev2[3]), .code_violation_event(ev2[2]),
        .one_second_timer_event(ev2[1]), .error_count_tick(tick), .e1_mode(e1_mode),
        .first_event_mask(msk1), .first_edge_select(sel1), .second_event_mask(msk2),
        .second_edge_select(sel2), .interrupt_request(irq), .tx_internal_match(tx_int),
        .tx_external_match(tx_ext), .rx_internal_match(rx_int), .rx_external_match(rx_ext));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clock) if (host_inst.pend_r) check(read_data, host_inst.exp_q.pop_front());
    initial begin
        #4ms;
        err_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(42));
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        ch = $urandom % 8;
        host_inst.rd(8'(ch*32+24), 8'h00);
        host_inst.rd(8'(ch*32+25), 8'h00);
        host_inst.rd(8'(ch*32+26), 8'h00);
        // one event per flag bit except counter overflow; the flag must stay set through the fall and clear on the first read
        for (b = 0; b < 15; b++) begin
            ch = $urandom % 8;
            if (b < 8) ev1[b][ch] <= 1'b1; else ev2[b-7][ch] <= 1'b1;
            host_inst.idle();
            repeat (3) @(posedge clock);
            if (b < 8) ev1[b][ch] <= 1'b0; else ev2[b-7][ch] <= 1'b0;
            @(negedge clock);
            check(irq, 8'(1 << ch));
            @(posedge clock);
            host_inst.rd(8'(ch*32 + (b < 8 ? 22 : 23)), 8'(1 << (b < 8 ? b : b-7)));
            host_inst.rd(8'(ch*32 + (b < 8 ? 22 : 23)), 8'h00);
            host_inst.idle();
            repeat (2) @(posedge clock);
            @(negedge clock);
            check(irq, 8'h00);
            @(posedge clock);
        end
        // any-change mode flags the fall as well; a masked event never sets its flag
        for (k = 0; k < 2; k++) begin
            ch = $urandom % 8;
            b = $urandom % 7 + 1;
            if (k == 0) begin
                sel1[ch*8+b] <= 1'b1;
                msk2[ch*8+b] <= 1'b1;
            end else begin
                sel2[ch*8+b] <= 1'b1;
                msk1[ch*8+b] <= 1'b1;
            end
            ev1[b][ch] <= 1'b1;
            ev2[b][ch] <= 1'b1;
            repeat (3) @(posedge clock);
            host_inst.rd(8'(ch*32+22+k), 8'(1 << b));
            host_inst.rd(8'(ch*32+23-k), 8'h00);
            ev1[b][ch] <= 1'b0;
            ev2[b][ch] <= 1'b0;
            host_inst.idle();
            repeat (2) @(posedge clock);
            host_inst.rd(8'(ch*32+22+k), 8'(1 << b));
            host_inst.rd(8'(ch*32+23-k), 8'h00);
            host_inst.rd(8'(ch*32+22+k), 8'h00);
            host_inst.idle();
            {sel1, sel2, msk1, msk2} <= '0;
            @(posedge clock);
        end
        ch = $urandom % 8;
        n = 256 + $urandom % 200;
        repeat (n) begin
            tick[ch] <= 1'b1;
            @(posedge clock);
        end
        tick[ch] <= 1'b0;
        @(posedge clock);
        host_inst.rd(8'(ch*32+24), 8'(n));
        host_inst.rd(8'(ch*32+25), 8'(n >> 8));
        host_inst.wr(8'(ch*32+24), 8'h55);
        host_inst.rd(8'(ch*32+24), 8'(n));
        // run the counter up to its wrap so the overflow flag is raised once
        host_inst.idle();
        tick[ch] <= 1'b1;
        repeat (65536 - n) @(posedge clock);
        tick[ch] <= 1'b0;
        @(posedge clock);
        host_inst.rd(8'(ch*32+23), 8'h01);
        host_inst.rd(8'(ch*32+24), 8'h00);
        host_inst.rd(8'(ch*32+25), 8'h00);
        d = $urandom | 32'h20;
        e1_mode <= 8'(1 << ch);
        host_inst.wr(8'(ch*32+26), 8'(d));
        host_inst.rd(8'(ch*32+26), 8'(d) & 8'h3F);
        host_inst.rd(8'(ch*32), 8'h00);
        host_inst.idle();
        repeat (3) @(posedge clock);
        @(negedge clock);
        check(8'(tx_int >> (2*ch)) & 8'h03, 8'(d >> 3) & 8'h03);
        check(8'(rx_int >> (2*ch)) & 8'h03, 8'(d) & 8'h03);
        check(tx_ext, 8'(((d >> 5) & 1) << ch));
        check(rx_ext, 8'(((d >> 2) & 1) << ch));
        @(posedge clock);
        e1_mode <= 8'h00;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check(tx_ext, 8'h00);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
